// *** rtl/rbps_pkg.sv ***
// shared constants and types for the reset, bus mode and power sequencer
package rbps_pkg;
  localparam logic [15:0] RBPS_TEST_DOWN = 16'h0100;
  localparam logic [15:0] RBPS_TEST_UP = 16'h3c04;
  localparam logic [13:0] RBPS_TEST_MASK = 14'h3fff;
  localparam int RBPS_BIAS_BIT = 15;
  localparam logic [7:0] RBPS_PDN_CYCLES = 8'h10;
  localparam logic [7:0] RBPS_PUP_CYCLES = 8'h20;
  localparam logic [15:0] RBPS_TEST_RESET = 16'h0100;
  // host register map (ahb byte offsets)
  localparam logic [31:0] RBPS_REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] RBPS_REG_STAT = 32'h0000_0004;
  localparam logic [31:0] RBPS_REG_TEST = 32'h0000_0008;
  typedef enum logic [3:0] {
    RBPS_OFF = 4'h1,
    RBPS_PUP = 4'h2,
    RBPS_ON = 4'h4,
    RBPS_PDN = 4'h8
  } rbps_pwr_type;
  typedef enum logic [4:0] {
    RBPS_H_RESET = 5'h01,
    RBPS_H_IDLE = 5'h02,
    RBPS_H_UPWAIT = 5'h04,
    RBPS_H_DNWAIT = 5'h08,
    RBPS_H_RDS = 5'h10
  } rbps_host_type;
endpackage : rbps_pkg

// *** rtl/rbps_if.sv ***
// pins and register port between the host controller and the tuner device
`timescale 1ns/1ps
`default_nettype none
interface rbps_if;
  logic rst_pin_b;
  logic serial_select_n;
  logic sdio_o;
  logic sdio_oe;
  logic sclk;
  logic wire_count_strap;
  logic method_select_strap_o;
  logic method_select_strap_oe;
  logic method_select_pull_dn;
  logic method_select_strap;
  logic ref_clk_run;
  logic wr;
  logic [15:0] wr_data;
  logic wr_test;
  logic rds_on;
  logic power_on;
  logic power_off;
  logic powered_up;
  logic seq_busy;
  logic two_wire;
  logic bus_live;
  logic [1:0] audio_bias;
  // wired level of the method pin: host drive, else weak pull-down, else float high
  assign method_select_strap = method_select_strap_oe ? method_select_strap_o :
                               (method_select_pull_dn ? 1'b0 : 1'b1);
  modport device (
    input rst_pin_b, serial_select_n, sdio_o, sdio_oe, sclk, wire_count_strap,
    input method_select_strap, ref_clk_run, wr, wr_data, wr_test, rds_on,
    output method_select_pull_dn, power_on, power_off, powered_up, seq_busy,
    output two_wire, bus_live, audio_bias
  );
  modport host (
    output rst_pin_b, serial_select_n, sdio_o, sdio_oe, sclk, wire_count_strap,
    output method_select_strap_o, method_select_strap_oe, ref_clk_run,
    output wr, wr_data, wr_test, rds_on,
    input power_on, power_off, powered_up, seq_busy, two_wire, bus_live
  );
endinterface : rbps_if
`default_nettype wire

// *** rtl/rbps_device.sv ***
// tuner device end: strap sampling, bus mode latch and power state machine
//
// Notes on behaviour
// - reset low disables device, clears registers
// - straps sampled at reset rise pick bus
// - method one: method pin and data low
// - weak pull-down only while reset low
// - method one: select high two-wire, low three
// - method two: method pin high at rise
// - method two: wire-count pin picks bus
// - two-wire: host keeps clock high until start
// - method two only without crystal oscillator
// - power bits start at zero
// - on=1 off=0 write powers up
// - on=1 off=1 runs powerdown, self-clears bits
// - host turns rds off before powerdown; host here masks rds only in the powerdown write cycle
// - host never writes power-on as zero
// - host keeps test word per power state
// - bias hold acts only when powered down
// - no bias register write during powerup
// - host initialisation order: reset, mode, clock, powerup
// - powerdown keeps registers while reset high
// - reference clock may stop after powerdown
// - reference clock runs while power-on set
// - oscillator switched only while powered down
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rbps_device #(
  parameter logic [7:0] PDN_CYCLES = rbps_pkg::RBPS_PDN_CYCLES,
  parameter logic [7:0] PUP_CYCLES = rbps_pkg::RBPS_PUP_CYCLES
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  rbps_if.device link,
  // user side
  output logic [15:0] test_reg,
  output logic mode_valid
);
  localparam int N_PINS = 5;
  wire logic [N_PINS-1:0] pin_raw;
  wire logic [N_PINS-1:0] pin_sync;
  wire logic [N_PINS-1:0] pin_prev;
  logic chip_rst;
  logic rise;
  rbps_pkg::rbps_pwr_type state;
  logic [7:0] cnt;
  logic on_bit;
  logic off_bit;
  logic two_wire_q;
  logic live_q;
  logic up_req;
  logic dn_req;
  logic seq_done;

  // slots: 0 reset pin, 1 select, 2 data, 3 wire count, 4 method
  assign pin_raw[0] = link.rst_pin_b;
  assign pin_raw[1] = link.serial_select_n;
  // a data line nobody drives idles high
  assign pin_raw[2] = link.sdio_oe ? link.sdio_o : 1'b1;
  assign pin_raw[3] = link.wire_count_strap;
  assign pin_raw[4] = link.method_select_strap;

  // pins come from the host's domain, so two stages each; the third stage
  // holds what the straps showed while reset was still low
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic meta_q;
    logic sync_q;
    logic prev_q;
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        meta_q <= pin_raw[i];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end
    assign pin_sync[i] = sync_q;
    assign pin_prev[i] = prev_q;
  end

  assign chip_rst = !rst_b || !pin_sync[0];
  // the pull-down lets go as soon as reset rises, so straps come from the stage before
  assign rise = pin_sync[0] && !pin_prev[0];
  assign link.method_select_pull_dn = !link.rst_pin_b;

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      two_wire_q <= 1'b0;
      live_q <= 1'b0;
    end else if (rise) begin
      live_q <= 1'b1;
      if (pin_prev[4]) begin
        two_wire_q <= pin_prev[3];
      end else begin
        // method one needs data low; a high data line is not a legal strap
        two_wire_q <= pin_prev[1];
        live_q <= !pin_prev[2];
      end
    end
  end

  // power writes count only while the bus is live and the state can take them
  assign up_req = state == rbps_pkg::RBPS_OFF && live_q && link.wr &&
                  link.wr_data[0] && !link.wr_data[1];
  assign dn_req = state == rbps_pkg::RBPS_ON && live_q && link.wr &&
                  link.wr_data[0] && link.wr_data[1];
  assign seq_done = cnt == 8'h01;

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      state <= rbps_pkg::RBPS_OFF;
    end else begin
      case (state)
        rbps_pkg::RBPS_OFF: begin
          if (up_req) begin
            state <= rbps_pkg::RBPS_PUP;
          end
        end
        rbps_pkg::RBPS_PUP: begin
          if (seq_done) begin
            state <= rbps_pkg::RBPS_ON;
          end
        end
        rbps_pkg::RBPS_ON: begin
          if (dn_req) begin
            state <= rbps_pkg::RBPS_PDN;
          end
        end
        rbps_pkg::RBPS_PDN: begin
          if (seq_done) begin
            state <= rbps_pkg::RBPS_OFF;
          end
        end
        default: begin
          state <= rbps_pkg::RBPS_OFF;
        end
      endcase
    end
  end

  // one counter serves both sequences; it only runs while busy
  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      cnt <= 8'h00;
    end else if (up_req) begin
      cnt <= PUP_CYCLES;
    end else if (dn_req) begin
      cnt <= PDN_CYCLES;
    end else if (state == rbps_pkg::RBPS_PUP || state == rbps_pkg::RBPS_PDN) begin
      cnt <= cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      on_bit <= 1'b0;
      off_bit <= 1'b0;
    end else if (up_req) begin
      on_bit <= 1'b1;
      off_bit <= 1'b0;
    end else if (dn_req) begin
      on_bit <= 1'b1;
      off_bit <= 1'b1;
    end else if (state == rbps_pkg::RBPS_PDN && seq_done) begin
      // both bits drop together as the powerdown ends
      on_bit <= 1'b0;
      off_bit <= 1'b0;
    end
  end

  // test word is kept through powerdown; only reset clears it
  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      test_reg <= rbps_pkg::RBPS_TEST_RESET;
    end else if (live_q && link.wr_test && state != rbps_pkg::RBPS_PUP) begin
      test_reg <= link.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      link.audio_bias <= 2'h0;
    end else if (state == rbps_pkg::RBPS_OFF) begin
      link.audio_bias <= {2{test_reg[rbps_pkg::RBPS_BIAS_BIT]}};
    end else begin
      link.audio_bias <= 2'h0;
    end
  end

  assign link.power_on = on_bit;
  assign link.power_off = off_bit;
  assign link.powered_up = state == rbps_pkg::RBPS_ON;
  assign link.seq_busy = state == rbps_pkg::RBPS_PUP || state == rbps_pkg::RBPS_PDN;
  assign link.two_wire = two_wire_q;
  assign link.bus_live = live_q;
  assign mode_valid = live_q;
endmodule : rbps_device
`default_nettype wire

// *** rtl/rbps_host.sv ***
// host controller end: ahb-lite registers drive reset, straps and power requests
`timescale 1ns/1ps
`default_nettype none
module rbps_host (
  // system
  input wire logic sys_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link
  rbps_if.host link
);
  logic ap_wr;
  logic ap_rd;
  logic [31:0] ap_addr;
  logic [31:0] ctrl;
  logic [15:0] test_shadow;
  logic [15:0] next_wr_data;
  logic [15:0] test_word;
  logic wr_q;
  logic wr_test_q;
  logic [1:0] st_sync;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 32'h0;
    end else if (hready) begin
      ap_wr <= hsel && htrans[1] && hwrite;
      ap_rd <= hsel && htrans[1] && !hwrite;
      ap_addr <= haddr;
    end
  end

  // ctrl: 0 reset pin, 1 method high, 2 wire count, 3 select, 4 data low, 5 rclk, 6 rds
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl <= 32'h0000_0018;
    end else if (ap_wr && ap_addr == rbps_pkg::RBPS_REG_CTRL) begin
      ctrl <= hwdata;
    end
  end

  // power writes always carry power-on high; rds is masked only in the cycle of the powerdown write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      wr_test_q <= 1'b0;
      next_wr_data <= 16'h0;
      test_shadow <= rbps_pkg::RBPS_TEST_DOWN;
    end else begin
      wr_q <= 1'b0;
      wr_test_q <= 1'b0;
      if (ap_wr && ap_addr == rbps_pkg::RBPS_REG_STAT) begin
        wr_q <= 1'b1;
        next_wr_data <= {14'h0, hwdata[0], 1'b1};
      end else if (ap_wr && ap_addr == rbps_pkg::RBPS_REG_TEST && !link.seq_busy) begin
        wr_test_q <= 1'b1;
        next_wr_data <= test_word;
        test_shadow <= test_word;
      end
    end
  end

  // only the bias bit is software's; the low word follows power state
  assign test_word = {hwdata[15], 1'b0,
                      link.powered_up ? rbps_pkg::RBPS_TEST_UP[13:0]
                                      : rbps_pkg::RBPS_TEST_DOWN[13:0]};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_sync <= 2'h0;
    end else begin
      st_sync <= {st_sync[0], link.powered_up};
    end
  end

  assign link.rst_pin_b = ctrl[0];
  assign link.method_select_strap_o = ctrl[1];
  assign link.method_select_strap_oe = ctrl[1];
  assign link.wire_count_strap = ctrl[2];
  assign link.serial_select_n = ctrl[3];
  assign link.sdio_o = !ctrl[4];
  assign link.sdio_oe = 1'b1;
  assign link.sclk = 1'b1;
  // rclk forced on whenever power-on is set
  assign link.ref_clk_run = ctrl[5] || link.power_on;
  assign link.rds_on = ctrl[6] && !(wr_q && next_wr_data[1]);
  assign link.wr = wr_q;
  assign link.wr_test = wr_test_q;
  assign link.wr_data = next_wr_data;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    hrdata = 32'h0;
    if (ap_rd) begin
      case (ap_addr)
        rbps_pkg::RBPS_REG_CTRL: hrdata = ctrl;
        rbps_pkg::RBPS_REG_STAT: hrdata = {26'h0, link.bus_live, link.two_wire,
                                           link.seq_busy, st_sync[1],
                                           link.power_off, link.power_on};
        rbps_pkg::RBPS_REG_TEST: hrdata = {16'h0, test_shadow};
        default: hrdata = 32'h0;
      endcase
    end
  end
endmodule : rbps_host
`default_nettype wire

// *** tb/rbps_props.sv ***
// checker for the link between the host controller and the tuner device
`timescale 1ns/1ps
`default_nettype none
module rbps_props #(
  parameter int PUP_N = 2,
  parameter int PDN_N = 2
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  input wire logic rst_pin_b,
  input wire logic serial_select_n,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic wire_count_strap,
  input wire logic method_select_strap,
  input wire logic method_select_pull_dn,
  input wire logic wr,
  input wire logic [15:0] wr_data,
  input wire logic power_on,
  input wire logic power_off,
  input wire logic powered_up,
  input wire logic seq_busy,
  input wire logic two_wire,
  input wire logic bus_live,
  input wire logic [1:0] audio_bias
);
  // margin over the sequence counts for request and sync latency
  localparam int UP_MAX = PUP_N + 6;
  localparam int DN_MAX = PDN_N + 6;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_m1;
    $rose(rst_pin_b) && !$past(method_select_strap);
  endsequence
  sequence s_up_req;
    wr && wr_data[1:0] == 2'b01 && bus_live && !power_on && !seq_busy;
  endsequence
  sequence s_dn_req;
    wr && wr_data[1:0] == 2'b11 && powered_up && !seq_busy;
  endsequence
  chk_pull_dn_level: assert property (method_select_pull_dn == !rst_pin_b)
    else $error("pull-down not tied to reset pin");
  chk_reset_quiet: assert property (!rst_pin_b [*4] |-> !bus_live && !power_on && !power_off)
    else $error("device active in reset");
  chk_method_two: assert property ($rose(rst_pin_b) && $past(method_select_strap) |->
    ##4 bus_live && two_wire == $past(wire_count_strap, 5))
    else $error("method two mode wrong");
  chk_method_one: assert property (s_m1 ##0 !$past(sdio_o) && $past(sdio_oe) |->
    ##4 bus_live && two_wire == $past(serial_select_n, 5))
    else $error("method one mode wrong");
  chk_bad_data: assert property (s_m1 ##0 $past(sdio_o) |-> ##4 !bus_live)
    else $error("bus live with data high");
  chk_mode_hold: assert property (rst_pin_b [*6] |-> $stable(two_wire) && $stable(bus_live))
    else $error("bus mode changed");
  chk_init_zero: assert property ($rose(rst_b) |-> !power_on && !power_off)
    else $error("power bits not clear");
  chk_power_up: assert property (s_up_req |-> ##[1:UP_MAX] powered_up && power_on && !power_off)
    else $error("powerup missing");
  chk_power_dn: assert property (s_dn_req |-> ##[1:DN_MAX] !power_on && !power_off && !powered_up)
    else $error("powerdown missing");
  chk_bias_up: assert property (powered_up && $past(powered_up) |-> audio_bias == 2'b00)
    else $error("bias held in powerup");
endmodule : rbps_props
`default_nettype wire

// *** tb/rbps_tb.sv ***
// testbench joining host and device ends over the link interface
`timescale 1ns/1ps
`default_nettype none
module rbps_tb;
  logic sys_clk, rst_b, hwrite, hreadyout, hresp, mode_valid, hsel, hsel_en;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [15:0] test_reg;
  logic [6:0] c;
  logic [6:0] corner [5] = '{7'h10, 7'h18, 7'h08, 7'h02, 7'h06};
  int n_fail = 0;
  int checked = 0;
  rbps_if u_rbps_if ();
  rbps_host u_rbps_host (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(u_rbps_if));
  // short sequence counts keep the run brief
  rbps_device #(.PDN_CYCLES(8'h02), .PUP_CYCLES(8'h02)) u_rbps_device (.sys_clk(sys_clk),
    .rst_b(rst_b), .link(u_rbps_if), .test_reg(test_reg), .mode_valid(mode_valid));
  rbps_props #(.PUP_N(2), .PDN_N(2)) u_rbps_props (.sys_clk(sys_clk), .rst_b(rst_b),
    .rst_pin_b(u_rbps_if.rst_pin_b), .serial_select_n(u_rbps_if.serial_select_n),
    .sdio_o(u_rbps_if.sdio_o), .sdio_oe(u_rbps_if.sdio_oe),
    .wire_count_strap(u_rbps_if.wire_count_strap),
    .method_select_strap(u_rbps_if.method_select_strap),
    .method_select_pull_dn(u_rbps_if.method_select_pull_dn), .wr(u_rbps_if.wr),
    .wr_data(u_rbps_if.wr_data), .power_on(u_rbps_if.power_on),
    .power_off(u_rbps_if.power_off), .powered_up(u_rbps_if.powered_up),
    .seq_busy(u_rbps_if.seq_busy), .two_wire(u_rbps_if.two_wire),
    .bus_live(u_rbps_if.bus_live), .audio_bias(u_rbps_if.audio_bias));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction : xs
  // floating method pin reads low through the pull-down
  function logic [1:0] exp_mode(input logic [6:0] v);
    if (v[1]) exp_mode = {1'b1, v[2]};
    else if (v[4]) exp_mode = {1'b1, v[3]};
    else exp_mode = 2'b00;
  endfunction : exp_mode
  task stop_test;
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= hsel_en;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    r = hrdata;
  endtask : ahb
  task bring_up(input logic [6:0] v);
    logic [1:0] em;
    em = exp_mode(v);
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, {25'h0, v & 7'h7e});
    repeat (4) @(posedge sys_clk);
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, {25'h0, v | 7'h01});
    repeat (8) @(posedge sys_clk);
    ahb(rbps_pkg::RBPS_REG_STAT, 1'b0, 32'h0);
    chk({14'h0, r[5], r[5] & r[4]}, {14'h0, em});
    chk({15'h0, mode_valid}, {15'h0, em[1]});
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, {25'h0, (v | 7'h01) ^ 7'h1e});
    repeat (4) @(posedge sys_clk);
    ahb(rbps_pkg::RBPS_REG_STAT, 1'b0, 32'h0);
    chk({14'h0, r[5], r[5] & r[4]}, {14'h0, em});
  endtask : bring_up
  task poll(input logic [3:0] want);
    int k;
    k = 0;
    // start from a mismatch so the status is always read at least once
    r = ~{28'h0, want};
    while (r[3:0] !== want && k < 100) begin
      ahb(rbps_pkg::RBPS_REG_STAT, 1'b0, 32'h0);
      k++;
    end
    chk({12'h0, r[3:0]}, {12'h0, want});
  endtask : poll
  initial begin
    rst_b = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsel = 1'b0;
    hsel_en = 1'b1;
    seed = 32'h45ab;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      c = (i < 5) ? corner[i] : seed[6:0];
      bring_up((c & 7'h1e) | 7'h20);
    end
    bring_up(7'h26);
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, 32'h67);
    ahb(rbps_pkg::RBPS_REG_STAT, 1'b1, 32'h0);
    poll(4'b0101);
    ahb(rbps_pkg::RBPS_REG_TEST, 1'b1, 32'h0000_bc04);
    repeat (2) @(posedge sys_clk);
    chk({14'h0, u_rbps_if.audio_bias}, 16'h0000);
    // rds off first, else powerdown may misbehave
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, 32'h27);
    ahb(rbps_pkg::RBPS_REG_STAT, 1'b1, 32'h1);
    poll(4'b0000);
    ahb(rbps_pkg::RBPS_REG_TEST, 1'b1, 32'h0000_8000);
    repeat (20) @(posedge sys_clk);
    chk(test_reg, {2'b10, rbps_pkg::RBPS_TEST_DOWN[13:0]});
    chk({14'h0, u_rbps_if.audio_bias}, 16'h0003);
    ahb(rbps_pkg::RBPS_REG_TEST, 1'b0, 32'h0);
    chk(r[15:0], {2'b10, rbps_pkg::RBPS_TEST_DOWN[13:0]});
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, 32'h26);
    repeat (6) @(posedge sys_clk);
    chk(test_reg, rbps_pkg::RBPS_TEST_RESET);
    // an unselected write must leave the reset pin low
    hsel_en = 1'b0;
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b1, 32'h7f);
    hsel_en = 1'b1;
    ahb(rbps_pkg::RBPS_REG_CTRL, 1'b0, 32'h0);
    chk(r[15:0], 16'h0026);
    stop_test();
  end
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule : rbps_tb
`default_nettype wire
